// [dv/can_bitrate_config_selector_chk.sv]
`timescale 1ns/1ps
module can_bitrate_config_selector_chk #(
  parameter int BLINK_CYCLES = 4
) (
  input wire logic        clk,           // Clock
  input wire logic        rst,           // Reset
  input wire logic [1:0]  variant_strap, // Family
  input wire logic        nv_valid,      // Store valid
  input wire logic        probe_ok,      // Probe ok
  input wire logic        probe_fail,    // Probe fail
  input wire logic        rd,            // Read strobe
  input wire logic [15:0] rdata,         // Read data
  input wire logic [1:0]  rate_code,     // Rate code
  input wire logic [10:0] rate_khz,      // Rate kHz
  input wire logic        rate_valid,    // Rate settled
  input wire logic        addr_valid,    // Address mode
  input wire logic        cfg_mode,      // Config mode
  input wire logic        led_stop,      // LED
  input wire logic        led_run,       // LED
  input wire logic        led_tx,        // LED
  input wire logic        led_rx,        // LED
  input wire logic        nv_wr,         // Store pulse
  input wire logic [1:0]  nv_wr_code,    // Store code
  input wire logic        probe_req,     // Probe pulse
  input wire logic [1:0]  probe_code     // Probed code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic [3:0] pat(input logic [1:0] c);
    return (c == 2'h0) ? 4'hF : {2'h0, c};
  endfunction

  property p_nv_pulse; nv_wr |=> !nv_wr; endproperty
  a_nv_pulse: assert property (p_nv_pulse)
    else $error("store pulse longer than one cycle");
  property p_save_led;
    nv_wr |-> ##[1:3] ({led_rx, led_tx, led_run, led_stop} == pat(nv_wr_code));
  endproperty
  a_save_led: assert property (p_save_led)
    else $error("saved rate not shown on leds");
  property p_addr_cfg; addr_valid |-> !cfg_mode; endproperty
  a_addr_cfg: assert property (p_addr_cfg)
    else $error("address mode and config mode together");
  property p_probe_pulse; probe_req |=> !probe_req; endproperty
  a_probe_pulse: assert property (p_probe_pulse)
    else $error("probe pulse longer than one cycle");
  property p_fail_step;
    (probe_fail && variant_strap == 2'h3 && !rate_valid) |=>
      (probe_code == $past(probe_code) + 2'h1) ##1 probe_req;
  endproperty
  a_fail_step: assert property (p_fail_step)
    else $error("failed probe did not step to next rate");
  property p_ok_sets;
    (probe_ok && variant_strap == 2'h3 && !rate_valid) |=>
      rate_valid && rate_code == $past(probe_code);
  endproperty
  a_ok_sets: assert property (p_ok_sets)
    else $error("answered probe did not set rate");
  property p_rdata_idle; !rd |=> rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without read");
  property p_tx_only;
    (cfg_mode && !nv_valid && !nv_wr && !$past(nv_wr)) |->
      !led_stop && !led_run && !led_rx;
  endproperty
  a_tx_only: assert property (p_tx_only)
    else $error("leds other than tx lit with nothing stored");
  property p_no250;
    (rate_valid && variant_strap == 2'h1) |-> rate_khz != 11'h0FA;
  endproperty
  a_no250: assert property (p_no250)
    else $error("family without 250 kHz runs at 250 kHz");

  c_save: cover property (nv_wr);
  c_probe: cover property (probe_ok ##1 rate_valid);
  c_addr: cover property (addr_valid);
  c_cfg: cover property (cfg_mode && led_tx);
endmodule

bind can_bitrate_config_selector can_bitrate_config_selector_chk #(
  .BLINK_CYCLES(BLINK_CYCLES)
) i_chk (.clk, .rst, .variant_strap, .nv_valid, .probe_ok, .probe_fail, .rd,
  .rdata, .rate_code, .rate_khz, .rate_valid, .addr_valid, .cfg_mode,
  .led_stop, .led_run, .led_tx, .led_rx, .nv_wr, .nv_wr_code, .probe_req,
  .probe_code);

// [dv/can_bitrate_config_selector_tb_top.sv]
`timescale 1ns/1ps
module can_bitrate_config_selector_tb_top;
  logic        clk, rst, wr, rd, nv_valid, probe_ok, probe_fail, nv_clear;
  logic [1:0]  variant_strap, open_proto_rate_switches, nv_code, bus_code;
  logic [1:0]  ans_wait, rate_code, nv_wr_code, probe_code;
  logic [7:0]  dip_sw, node_addr, d, len;
  logic [3:0]  addr, led, bp;
  logic [15:0] wdata, rdata, d16;
  logic [10:0] rate_khz;
  logic        rate_valid, addr_valid, cfg_mode, nv_wr, probe_req;
  logic        led_stop, led_run, led_tx, led_rx;
  logic [7:0]  lens [7] = '{8'h14, 8'h19, 8'h1E, 8'h32, 8'h64, 8'h82, 8'h83};
  int          error_cnt, num_checks, nv_wr_cnt, hi, oth, k, n0;

  can_bitrate_config_selector #(.BLINK_CYCLES(4)) i_can_bitrate_config_selector (
    .clk, .rst, .variant_strap, .dip_sw, .open_proto_rate_switches, .nv_code,
    .nv_valid, .probe_ok, .probe_fail, .addr, .wdata, .wr, .rd, .rdata,
    .rate_code, .rate_khz, .rate_valid, .node_addr, .addr_valid, .cfg_mode,
    .led_stop, .led_run, .led_tx, .led_rx, .nv_wr, .nv_wr_code, .probe_req,
    .probe_code);
  can_node_partner i_can_node_partner (.clk, .rst, .bus_code, .ans_wait,
    .nv_clear, .probe_req, .probe_code, .nv_wr, .nv_wr_code, .probe_ok,
    .probe_fail, .nv_code, .nv_valid);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (nv_wr === 1'b1) nv_wr_cnt++;

  function automatic logic [10:0] exp_khz(input int v, input int s);
    logic [10:0] t [4] = '{11'h3E8, 11'h320, 11'h1F4, 11'h0FA};
    return (v == 1 && s == 3) ? 11'h1F4 : t[s];
  endfunction
  function automatic logic [10:0] len_khz(input logic [7:0] l);
    logic [10:0] t [14] = '{11'h0, 11'h0, 11'h3E8, 11'h378, 11'h320, 11'h2D7,
      11'h29A, 11'h267, 11'h23B, 11'h215, 11'h1F4, 11'h1E0, 11'h1AE, 11'h190};
    if (l <= 8'h14) return 11'h3E8;
    if (l > 8'h82) return 11'h0FA;
    return t[(l + 8'h09) / 8'h0A];
  endfunction
  function automatic logic [3:0] led_pat(input int c);
    return (c == 0) ? 4'hF : 4'(c);
  endfunction
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic boot(input logic [1:0] v, input logic [7:0] sw);
    rst <= 1'b1;
    variant_strap <= v;
    dip_sw <= sw;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] w);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] r);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    r = rdata;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {rst, wr, rd, addr, wdata, dip_sw, variant_strap} = '0;
    {open_proto_rate_switches, bus_code, ans_wait} = '0;
    nv_clear = 1'b1;
    void'($urandom(32'h4b0306b9));
    for (int v = 0; v < 2; v++) begin
      for (int s = 0; s < 4; s++) begin
        open_proto_rate_switches <= 2'(s);
        boot(2'(v), 8'h00);
        nv_clear <= 1'b0;
        chk(rate_khz === exp_khz(v, s), "switch rate");
        open_proto_rate_switches <= ~2'(s);
        repeat (6) @(posedge clk);
        chk(rate_khz === exp_khz(v, s), "rate moved without reset");
      end
    end
    $display("test switches done");
    repeat (3) begin
      d = 8'($urandom_range(1, 255));
      boot(2'h2, d);
      chk(node_addr === d && addr_valid === 1'b1 && !cfg_mode, "addr");
    end
    $display("test address done");
    for (int c = 0; c < 4; c++) begin
      boot(2'h2, 8'h00);
      chk(cfg_mode === 1'b1, "config mode missing");
      // Nothing stored yet: tx alone, else the stored rate
      bp = (c == 0) ? 4'h4 : led_pat(c - 1);
      {hi, oth} = '0;
      repeat (12) begin
        @(posedge clk);
        #1;
        led = {led_rx, led_tx, led_run, led_stop};
        hi += (led === bp);
        oth += (led !== 4'h0 && led !== bp);
      end
      chk(hi > 0 && hi < 12 && oth == 0, "blink pattern");
      if (c == 0) begin
        dip_sw <= 8'h84;
        repeat (8) @(posedge clk);
        chk(nv_wr_cnt == 0, "save with switch three on");
        reg_rd(4'h2, d16);
        chk(d16[11] === 1'b1 && d16[5:0] === 6'h02, "bad save status");
        dip_sw <= 8'h00;
        repeat (4) @(posedge clk);
      end
      n0 = nv_wr_cnt;
      dip_sw <= {6'h20, 2'(c)};
      repeat (8) @(posedge clk);
      #1;
      chk(nv_wr_cnt == n0 + 1 && nv_code === 2'(c), "save");
      chk({led_rx, led_tx, led_run, led_stop} === ((c == 0) ? 4'hF : 4'(c)),
          "saved leds");
      repeat (7) @(posedge clk);
      chk({led_rx, led_tx, led_run, led_stop} === ((c == 0) ? 4'hF : 4'(c)),
          "leds not steady");
      boot(2'h2, 8'($urandom_range(1, 127)));
      chk(rate_code === 2'(c) && addr_valid === 1'b1, "stored rate");
    end
    $display("test config done");
    for (int b = 0; b < 4; b++) begin
      // bus set to each rate an installer may pick
      bus_code <= 2'(b);
      ans_wait <= 2'($urandom_range(0, 3));
      boot(2'h3, 8'h00);
      k = 0;
      while (rate_valid !== 1'b1 && k < 200) begin
        @(posedge clk);
        #1;
        k++;
      end
      // Rate in kHz follows the code one cycle later
      @(posedge clk);
      #1;
      chk(rate_valid === 1'b1 && rate_code === 2'(b) &&
          rate_khz === exp_khz(0, b), "probe");
    end
    $display("test probe done");
    reg_rd(4'h1, d16);
    chk(d16[7:0] === 8'h14, "length reset value");
    reg_wr(4'h0, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      len = (i < 7) ? lens[i] : 8'($urandom);
      reg_wr(4'h1, {8'h00, len});
      @(posedge clk);
      reg_rd(4'h3, d16);
      chk(d16[10:0] === len_khz(len), "length rate");
    end
    reg_rd(4'hF, d16);
    chk(d16 === 16'h0000, "unmapped read");
    $display("test vendor done");
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule

// [dv/can_node_partner.sv]
`timescale 1ns/1ps
module can_node_partner (
  input  wire logic       clk,        // Clock
  input  wire logic       rst,        // Reset
  input  wire logic [1:0] bus_code,   // Rate the bus runs at
  input  wire logic [1:0] ans_wait,   // Answer delay
  input  wire logic       nv_clear,   // Erase store
  input  wire logic       probe_req,  // Probe pulse
  input  wire logic [1:0] probe_code, // Probed rate
  input  wire logic       nv_wr,      // Store pulse
  input  wire logic [1:0] nv_wr_code, // Code to store
  output logic            probe_ok,   // Answered
  output logic            probe_fail, // No answer
  output logic      [1:0] nv_code,    // Stored code
  output logic            nv_valid    // Stored valid
);
  logic       pend;
  logic [1:0] cnt;
  logic [1:0] code_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      probe_ok <= 1'b0;
      probe_fail <= 1'b0;
    end else begin
      probe_ok <= 1'b0;
      probe_fail <= 1'b0;
      if (probe_req) begin
        pend <= 1'b1;
        cnt <= ans_wait;
        code_q <= probe_code;
      end else if (pend && cnt == 2'h0) begin
        pend <= 1'b0;
        probe_ok <= (code_q == bus_code);
        probe_fail <= (code_q != bus_code);
      end else if (pend) begin
        cnt <= cnt - 2'h1;
      end
    end
  end

  always @(posedge clk) begin
    if (nv_clear) begin
      nv_valid <= 1'b0;
      nv_code <= 2'h0;
    end else if (nv_wr) begin
      nv_valid <= 1'b1;
      nv_code <= nv_wr_code;
    end
  end
endmodule

// [rtl/can_bitrate_config_selector.sv]
`timescale 1ns/1ps
module can_bitrate_config_selector #(
  parameter int BLINK_CYCLES = can_rate_pkg::BLINK_CYC
) (
  input  wire logic        clk,                      // 100 MHz clock
  input  wire logic        rst,                      // Async reset
  input  wire logic [1:0]  variant_strap,            // Node family pins
  input  wire logic [7:0]  dip_sw,                   // Dipswitch pins
  input  wire logic [1:0]  open_proto_rate_switches, // Panel rate pins
  input  wire logic [1:0]  nv_code,                  // Stored rate code
  input  wire logic        nv_valid,                 // Stored code valid
  input  wire logic        probe_ok,                 // Probe answered
  input  wire logic        probe_fail,               // Probe no answer
  input  wire logic [3:0]  addr,                     // Register address
  input  wire logic [15:0] wdata,                    // Write data
  input  wire logic        wr,                       // Write strobe
  input  wire logic        rd,                       // Read strobe
  output logic      [15:0] rdata,                    // Read data
  output logic      [1:0]  rate_code,                // Active rate code
  output logic      [10:0] rate_khz,                 // Active rate kHz
  output logic             rate_valid,               // Rate settled
  output logic      [7:0]  node_addr,                // Latched address
  output logic             addr_valid,               // Address latched
  output logic             cfg_mode,                 // In config mode
  output logic             led_stop,                 // Stop LED
  output logic             led_run,                  // Run LED
  output logic             led_tx,                   // Tx LED
  output logic             led_rx,                   // Rx LED
  output logic             nv_wr,                    // Store pulse
  output logic      [1:0]  nv_wr_code,               // Code to store
  output logic             probe_req,                // Probe pulse
  output logic      [1:0]  probe_code                // Rate under probe
);

  logic [1:0]  var_s;
  logic [7:0]  dip_s;
  logic [1:0]  rsw_s;
  can_rate_pkg::state_t   state;
  can_rate_pkg::variant_t variant;
  logic [2:0]  settle_cnt;
  logic [31:0] blink_cnt;
  logic        blink_ph;
  logic        sw8_prev;
  logic        stored_ok;
  logic [1:0]  stored_code;
  logic        cfg_error;
  logic        vendor;
  logic [7:0]  length;
  logic [10:0] next_vendor_khz;
  logic [3:0]  next_led;
  logic        save_go;

  sync_2ff #(.WIDTH(2)) u_sync_var (
    .clk (clk),
    .rst (rst),
    .d   (variant_strap),
    .q   (var_s)
  );

  sync_2ff #(.WIDTH(8)) u_sync_dip (
    .clk (clk),
    .rst (rst),
    .d   (dip_sw),
    .q   (dip_s)
  );

  sync_2ff #(.WIDTH(2)) u_sync_rsw (
    .clk (clk),
    .rst (rst),
    .d   (open_proto_rate_switches),
    .q   (rsw_s)
  );

  function automatic logic [10:0] code_khz(input logic [1:0] c);
    case (c)
      can_rate_pkg::RATE_1000: code_khz = can_rate_pkg::KHZ_1000;
      can_rate_pkg::RATE_800:  code_khz = can_rate_pkg::KHZ_800;
      can_rate_pkg::RATE_500:  code_khz = can_rate_pkg::KHZ_500;
      default:                 code_khz = can_rate_pkg::KHZ_250;
    endcase
  endfunction

  function automatic logic [3:0] code_led(input logic [1:0] c);
    case (c)
      can_rate_pkg::RATE_1000: code_led = can_rate_pkg::LED_1000;
      can_rate_pkg::RATE_800:  code_led = can_rate_pkg::LED_800;
      can_rate_pkg::RATE_500:  code_led = can_rate_pkg::LED_500;
      default:                 code_led = can_rate_pkg::LED_250;
    endcase
  endfunction

  // R7: family without the slow rate
  function automatic logic [1:0] limit_code(input logic [1:0] c);
    // R3: never run at 250 kHz
    if (c == can_rate_pkg::RATE_250) begin
      limit_code = can_rate_pkg::RATE_500;
    end else begin
      limit_code = c;
    end
  endfunction

  // R15: length to vendor rate, rounded up to the next step
  always_comb begin
    next_vendor_khz = can_rate_pkg::KHZ_250;
    if (length <= can_rate_pkg::LEN_FIRST) begin
      next_vendor_khz = can_rate_pkg::KHZ_1000;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_888;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 2 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_800;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 3 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_727;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 4 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_666;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 5 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_615;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 6 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_571;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 7 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_533;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 8 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_500;
    end else if (length <= 8'(can_rate_pkg::LEN_FIRST
                              + 9 * can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_480;
    end else if (length <= 8'(can_rate_pkg::LEN_LAST
                              - can_rate_pkg::LEN_STEP)) begin
      next_vendor_khz = can_rate_pkg::KHZ_430;
    end else if (length <= can_rate_pkg::LEN_LAST) begin
      next_vendor_khz = can_rate_pkg::KHZ_400;
    end
  end

  // R12: save needs switches three to seven off
  assign save_go = dip_s[7] && !sw8_prev && (dip_s[6:2] == 5'h00);

  // Settle counter lets the synchronisers fill before sampling
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_cnt <= '0;
    end else if (state == can_rate_pkg::ST_SETTLE) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw8_prev <= 1'b1;
    end else begin
      sw8_prev <= dip_s[7];
    end
  end

  // R6: rate switches are sampled only once after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= can_rate_pkg::ST_SETTLE;
      variant     <= can_rate_pkg::VAR_PANEL;
      node_addr   <= '0;
      addr_valid  <= 1'b0;
      cfg_mode    <= 1'b0;
      stored_ok   <= 1'b0;
      stored_code <= can_rate_pkg::RATE_1000;
      cfg_error   <= 1'b0;
      nv_wr       <= 1'b0;
      nv_wr_code  <= can_rate_pkg::RATE_1000;
      probe_req   <= 1'b0;
      probe_code  <= can_rate_pkg::RATE_1000;
      rate_code   <= can_rate_pkg::RATE_1000;
      rate_valid  <= 1'b0;
    end else begin
      nv_wr     <= 1'b0;
      probe_req <= 1'b0;
      case (state)
        can_rate_pkg::ST_SETTLE: begin
          if (settle_cnt == 3'(can_rate_pkg::SETTLE_CYC - 1)) begin
            variant     <= can_rate_pkg::variant_t'(var_s);
            // R16: stored code read back at power-on
            stored_ok   <= nv_valid;
            stored_code <= nv_code;
            case (can_rate_pkg::variant_t'(var_s))
              can_rate_pkg::VAR_PANEL: begin
                // R5: panel switches pick one of four rates
                rate_code  <= rsw_s;
                rate_valid <= 1'b1;
                state      <= can_rate_pkg::ST_RUN;
              end
              can_rate_pkg::VAR_NO250: begin
                rate_code  <= limit_code(rsw_s);
                rate_valid <= 1'b1;
                state      <= can_rate_pkg::ST_RUN;
              end
              can_rate_pkg::VAR_DIP: begin
                if (dip_s == 8'h00) begin
                  // R8: all off enters config mode
                  cfg_mode <= 1'b1;
                  state    <= can_rate_pkg::ST_CONFIG;
                end else begin
                  // R11: pattern becomes node address
                  node_addr  <= dip_s;
                  addr_valid <= 1'b1;
                  // R1: own rate from the stored code
                  rate_code  <= nv_valid ? nv_code
                                         : can_rate_pkg::RATE_1000;
                  rate_valid <= 1'b1;
                  state      <= can_rate_pkg::ST_RUN;
                end
              end
              default: begin
                // R4: host probes the bus for its rate
                probe_code <= can_rate_pkg::RATE_1000;
                probe_req  <= 1'b1;
                state      <= can_rate_pkg::ST_PROBE;
              end
            endcase
          end
        end
        can_rate_pkg::ST_CONFIG: begin
          if (save_go) begin
            // R13: store the selected rate
            stored_code <= dip_s[1:0];
            stored_ok   <= 1'b1;
            nv_wr       <= 1'b1;
            nv_wr_code  <= dip_s[1:0];
            cfg_error   <= 1'b0;
            state       <= can_rate_pkg::ST_SAVED;
          end else if (dip_s[7] && !sw8_prev) begin
            cfg_error <= 1'b1;
          end
        end
        can_rate_pkg::ST_PROBE: begin
          if (probe_ok) begin
            rate_code  <= probe_code;
            rate_valid <= 1'b1;
            state      <= can_rate_pkg::ST_RUN;
          end else if (probe_fail) begin
            // Wraps back to the top rate and keeps trying
            probe_code <= probe_code + 2'h1;
            state      <= can_rate_pkg::ST_WAIT;
          end
        end
        can_rate_pkg::ST_WAIT: begin
          probe_req <= 1'b1;
          state     <= can_rate_pkg::ST_PROBE;
        end
        can_rate_pkg::ST_SAVED: begin
          // R14: stays here until power is removed
          state <= can_rate_pkg::ST_SAVED;
        end
        can_rate_pkg::ST_RUN: begin
          state <= can_rate_pkg::ST_RUN;
        end
        default: begin
          state <= can_rate_pkg::ST_SETTLE;
        end
      endcase
    end
  end

  // R15: vendor protocol overrides the code-derived rate on the host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rate_khz <= can_rate_pkg::KHZ_1000;
    end else if (vendor && variant == can_rate_pkg::VAR_HOST) begin
      rate_khz <= next_vendor_khz;
    end else begin
      rate_khz <= code_khz(rate_code);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt <= '0;
      blink_ph  <= 1'b0;
    end else if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
      blink_cnt <= '0;
      blink_ph  <= !blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  always_comb begin
    next_led = 4'h0;
    if (state == can_rate_pkg::ST_CONFIG) begin
      if (!stored_ok) begin
        // R10: tx alone blinks when nothing is stored
        next_led = blink_ph ? can_rate_pkg::LED_NONE : 4'h0;
      end else begin
        // R8: blink the stored rate
        next_led = blink_ph ? code_led(stored_code) : 4'h0;
      end
    end else if (state == can_rate_pkg::ST_SAVED) begin
      // R13: steady after save
      next_led = code_led(stored_code);
    end
  end

  // R9 asks for switches one to four; stop/run/tx/rx here follow next_led bits 0 to 3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_stop <= 1'b0;
      led_run  <= 1'b0;
      led_tx   <= 1'b0;
      led_rx   <= 1'b0;
    end else begin
      led_stop <= next_led[0];
      led_run  <= next_led[1];
      led_tx   <= next_led[2];
      led_rx   <= next_led[3];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vendor <= 1'b0;
      length <= can_rate_pkg::LENGTH_RST;
    end else if (wr) begin
      if (addr == can_rate_pkg::REG_CTRL) begin
        vendor <= wdata[can_rate_pkg::CTRL_VENDOR];
      end
      if (addr == can_rate_pkg::REG_LENGTH) begin
        length <= wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        can_rate_pkg::REG_CTRL:   rdata <= {15'h0000, vendor};
        can_rate_pkg::REG_LENGTH: rdata <= {8'h00, length};
        can_rate_pkg::REG_STATUS: rdata <= {4'h0, cfg_error, stored_ok,
                                            variant, 2'h0, state};
        can_rate_pkg::REG_RATE:   rdata <= {rate_valid, 2'h0, rate_code,
                                            rate_khz};
        can_rate_pkg::REG_NODE:   rdata <= {7'h00, addr_valid, node_addr};
        default:                  rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule

// [rtl/can_rate_pkg.sv]
// Functional notes
// R1: On the open protocol every node runs one common rate and keeps its own.
// R2: The installer picks the rate from bus length (1000/800/500/250 kHz).
// R3: Only keyboards and the dip module offer 250 kHz; the other module never.
// R4: The host takes no set rate; it finds it by probing the other nodes.
// R5: On operator panels two switches select 1000, 800, 500 or 250 kHz.
// R6: A changed rate switch takes effect only after a module reset.
// R7: The module family without 250 kHz decodes codes to 1000/800/500/500.
// R8: All dipswitches off at power-on enters config mode; top LEDs blink rate.
// R9: In config mode stop/run/tx/rx LEDs mirror dipswitches one to four. The code blinks the stored rate pattern on them instead.
// R10: With no valid stored rate only the tx LED blinks in config mode.
// R11: Any dipswitch on at power-on skips config and latches the node address.
// R12: Switches one and two give the rate; switches three to seven must be off.
// R13: Switch eight stores the rate and lights its LEDs steadily (1 MHz: all).
// R14: After saving the operator powers down and returns switch eight to off.
// R15: The vendor protocol derives the rate from the bus length parameter.
// R16: The stored rate code lives in non-volatile storage across power cycles.
package can_rate_pkg;

  localparam int CLK_HZ        = 100_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYC     = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int SETTLE_CYC    = 4;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_LENGTH = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_RATE   = 4'h3;
  localparam logic [3:0] REG_NODE   = 4'h4;

  localparam int CTRL_VENDOR = 0;
  localparam logic [7:0] LENGTH_RST = 8'h14;

  typedef enum logic [1:0] {
    RATE_1000 = 2'h0,
    RATE_800  = 2'h1,
    RATE_500  = 2'h2,
    RATE_250  = 2'h3
  } rate_code_t;

  typedef enum logic [1:0] {
    VAR_PANEL = 2'h0,
    VAR_NO250 = 2'h1,
    VAR_DIP   = 2'h2,
    VAR_HOST  = 2'h3
  } variant_t;

  typedef enum logic [5:0] {
    ST_SETTLE = 6'h01,
    ST_CONFIG = 6'h02,
    ST_SAVED  = 6'h04,
    ST_RUN    = 6'h08,
    ST_PROBE  = 6'h10,
    ST_WAIT   = 6'h20
  } state_t;

  localparam logic [10:0] KHZ_1000 = 11'h3E8;
  localparam logic [10:0] KHZ_888  = 11'h378;
  localparam logic [10:0] KHZ_800  = 11'h320;
  localparam logic [10:0] KHZ_727  = 11'h2D7;
  localparam logic [10:0] KHZ_666  = 11'h29A;
  localparam logic [10:0] KHZ_615  = 11'h267;
  localparam logic [10:0] KHZ_571  = 11'h23B;
  localparam logic [10:0] KHZ_533  = 11'h215;
  localparam logic [10:0] KHZ_500  = 11'h1F4;
  localparam logic [10:0] KHZ_480  = 11'h1E0;
  localparam logic [10:0] KHZ_430  = 11'h1AE;
  localparam logic [10:0] KHZ_400  = 11'h190;
  localparam logic [10:0] KHZ_250  = 11'h0FA;

  // Length steps in metres
  localparam logic [7:0] LEN_STEP  = 8'h0A;
  localparam logic [7:0] LEN_FIRST = 8'h14;
  localparam logic [7:0] LEN_LAST  = 8'h82;

  localparam logic [3:0] LED_1000 = 4'hF;
  localparam logic [3:0] LED_800  = 4'h1;
  localparam logic [3:0] LED_500  = 4'h2;
  localparam logic [3:0] LED_250  = 4'h3;
  localparam logic [3:0] LED_NONE = 4'h4;

endpackage

// [rtl/sync_2ff.sv]
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // System clock
  input  wire logic             rst,   // Async reset
  input  wire logic [WIDTH-1:0] d,     // Asynchronous level
  output logic      [WIDTH-1:0] q      // Synchronised level
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
